// >>> src/rtcu_regs.svh
// Register map, field positions, reset values and timing figures of the timekeeper control block.
// Included by the wave generator, the top level and the bench; holds definitions only.
`ifndef RTCU_REGS_SVH
`define RTCU_REGS_SVH

// Byte offsets on the register bus
`define RTCU_OFF_SEC 8'h00
`define RTCU_OFF_SSEC 8'h04
`define RTCU_OFF_RSSA 8'h0c
`define RTCU_OFF_CTRL 8'h10
`define RTCU_OFF_TRIM 8'h14
`define RTCU_OFF_STAT 8'h1c
`define RTCU_OFF_MASK 8'h20
`define RTCU_ADDR_HI 7

// Control register field positions
`define RTCU_CTRL_EN 0
`define RTCU_CTRL_SSEN 2
`define RTCU_CTRL_FLAG 7
`define RTCU_CTRL_SQEN 8
`define RTCU_FREQ_LO 9
`define RTCU_FREQ_HI 10
`define RTCU_MODE_LO 11
`define RTCU_MODE_HI 12
`define RTCU_CTRL_WEN 15
`define RTCU_TRIM_HI 7
`define RTCU_HTRANS_ACTIVE 1

// Interrupt status bits
`define RTCU_IRQ_W 3
`define RTCU_IRQ_ALARM 0
`define RTCU_IRQ_SEC 1
`define RTCU_IRQ_SYNC 2

// Reset values
`define RTCU_SEC_RST 32'h0000_0000
`define RTCU_SSEC_RST 8'h00
`define RTCU_TRIM_RST 8'h00
`define RTCU_STAT_RST 3'h0

// Times in ns, the clock period and the divider count for the sub-second tick
`define RTCU_CLK_NS 10
`define RTCU_TICK_NS 122070
`define RTCU_SYNC_NS 91553
`define RTCU_WARM_NS 10000
`define RTCU_SS_PER_TICK 5'h1f

`endif

// >>> src/rtcu_pkg.sv
// Types shared by the timekeeper control block.
// Assumes nothing beyond a SystemVerilog compiler.
package rtcu_pkg;
  typedef enum logic [1:0] {OSC_NOISE_IMM, OSC_QUIET, OSC_AUTO_WAIT, OSC_AUTO_NOWAIT} rtcu_osc_mode_t;
  typedef enum logic [1:0] {ST_RUN, ST_DEEP, ST_WARM} rtcu_osc_state_t;
endpackage

// >>> src/rtcu_wave_if.sv
// Bundle between the control block and its square-wave and tick generator.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface rtcu_wave_if;
  logic run;
  logic [7:0] trim;
  logic tick256;
  logic sq_1hz;
  logic sq_512hz;
  logic sq_4khz;
  modport gen (input run, input trim, output tick256, output sq_1hz, output sq_512hz, output sq_4khz);
  modport ctl (output run, output trim, input tick256, input sq_1hz, input sq_512hz, input sq_4khz);
endinterface

// >>> src/rtcu_oneshot.sv
// One-shot interval timer: busy for CYCLES clocks after start, then a done pulse.
// Assumes start is a one-cycle pulse; a new start restarts the interval.
`timescale 1ns/1ps
module rtcu_oneshot #(
  parameter int CYCLES = 4
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);
  localparam logic [W-1:0] ONE = W'(1);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= LOAD;
      busy <= 1'b1;
      done <= 1'b0;
    end
    else
    begin
      done <= busy && (cnt_q == ONE);
      busy <= busy && (cnt_q != ONE);
      cnt_q <= busy ? cnt_q - ONE : cnt_q;
    end
  end
endmodule

// >>> src/rtcu_wave_gen.sv
// Raw and trimmed 8192 Hz dividers, the 256 Hz tick and the calibration square waves.
// Assumes run gates only the trimmed path; the raw oscillator never stops.
`timescale 1ns/1ps
`include "rtcu_regs.svh"
module rtcu_wave_gen #(
  parameter int TICK_CYCLES = `RTCU_TICK_NS / `RTCU_CLK_NS
)(
  input wire logic clk,
  input wire logic rst_n,
  rtcu_wave_if.gen w
);
  localparam logic [15:0] BASE = 16'(TICK_CYCLES);
  logic [15:0] reload [2];
  logic [1:0] tick;
  logic [1:0] runs;
  logic raw_q;
  logic [12:0] comp_q;

  // Trim shifts the compensated period by whole clocks, coarse but monotonic
  assign reload[0] = BASE;
  assign reload[1] = BASE - {{8{w.trim[7]}}, w.trim};
  assign runs = {w.run, 1'b1};

  genvar g;
  for (g = 0; g < 2; g = g + 1)
  begin : g_div
    logic [15:0] cnt_q;
    // Compare with >= so a trim change never strands the counter above reload
    assign tick[g] = runs[g] && (cnt_q >= reload[g] - 16'h0001);
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        cnt_q <= 16'h0000;
      else
        cnt_q <= (!runs[g] || tick[g]) ? 16'h0000 : cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      raw_q <= 1'b0;
      comp_q <= 13'h0000;
    end
    else
    begin
      raw_q <= raw_q ^ tick[0];
      comp_q <= comp_q + {12'h000, tick[1]};
    end
  end

  assign w.tick256 = tick[1] && (comp_q[4:0] == `RTCU_SS_PER_TICK);
  assign w.sq_4khz = raw_q;
  assign w.sq_512hz = comp_q[3];
  assign w.sq_1hz = comp_q[12];
endmodule

// >>> src/rtcu_top.sv
// Timekeeper control block: control register upper bits, counters, alarm, calibration output.
// Assumes a single AHB-Lite master, one 100 MHz clock, and pin-mux select from outside.
//
// Notes on behaviour
// - Trim and clock enable writes are taken only while write gate bit 15 is set.
// - Bits 31:16 and 14:13 reserved, read zero; software leaves them alone.
// - Oscillator mode 0 runs noise-immunity, mode 1 quiet without warm-up wait.
// - Mode 2 goes quiet in deep sleep and holds the processor through warm-up.
// - Mode 3 switches like mode 2 but never holds the processor.
// - Frequency 00 gives trimmed 1Hz, 01 trimmed 512Hz, 1x the raw 4kHz.
// - Frequency field matters only with square-wave enable and pin alternate function.
// - Square-wave enable 0 silences the calibration pin; 1 drives the chosen wave.
// - Square-wave enable clears on power-on reset.
// - Sub-second alarm sets the flag, a pending interrupt and wake-up source.
// - Busy shows while changes synchronise; software waits for busy low.
// - Sub-second counter runs at 256Hz and bumps seconds on wrap to zero.
`timescale 1ns/1ps
`include "rtcu_regs.svh"
module rtcu_top #(
  parameter int TICK_CYCLES = `RTCU_TICK_NS / `RTCU_CLK_NS,
  parameter int SYNC_CYCLES = (`RTCU_SYNC_NS + `RTCU_CLK_NS - 1) / `RTCU_CLK_NS,
  parameter int WARM_CYCLES = (`RTCU_WARM_NS + `RTCU_CLK_NS - 1) / `RTCU_CLK_NS
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic deep_low_power_state,
  input wire logic cal_alt_func_sel,
  output logic calibration_output_pin,
  output logic osc_quiet_mode,
  output logic cpu_hold,
  output logic wake_request,
  output logic irq
);
  import rtcu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic [`RTCU_ADDR_HI:0] addr_q;
  logic wr_q;
  logic rd_q;
  logic ready_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  wire take = hsel && hready && htrans[`RTCU_HTRANS_ACTIVE];
  wire take_rd = take && !hwrite;

  // Reads take one wait state so that data reflects writes just completed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ready_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      addr_q <= take ? haddr[`RTCU_ADDR_HI:0] : addr_q;
      wr_q <= take && hwrite;
      rd_q <= take_rd;
      ready_q <= !take_rd;
      rdata_q <= rd_q ? rd_mux : rdata_q;
    end
  end

  assign hreadyout = ready_q;
  assign hrdata = rdata_q;
  assign hresp = 1'b0;

  wire we_sec = wr_q && (addr_q == `RTCU_OFF_SEC);
  wire we_ssec = wr_q && (addr_q == `RTCU_OFF_SSEC);
  wire we_rssa = wr_q && (addr_q == `RTCU_OFF_RSSA);
  wire we_ctrl = wr_q && (addr_q == `RTCU_OFF_CTRL);
  wire we_trim = wr_q && (addr_q == `RTCU_OFF_TRIM);
  wire we_stat = wr_q && (addr_q == `RTCU_OFF_STAT);
  wire we_mask = wr_q && (addr_q == `RTCU_OFF_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic wen_q;
  logic enable_q;
  logic ss_en_q;
  logic flag_q;
  logic sq_en_q;
  logic [1:0] freq_q;
  rtcu_osc_mode_t mode_q;
  logic [7:0] trim_q;
  logic busy_w;
  logic alarm_evt;

  wire flag_clr = we_ctrl && !hwdata[`RTCU_CTRL_FLAG];
  // Alarm wins over a clearing write in the same cycle
  wire flag_d = alarm_evt || (flag_q && !flag_clr);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wen_q <= 1'b0;
      enable_q <= 1'b0;
      ss_en_q <= 1'b0;
      flag_q <= 1'b0;
      sq_en_q <= 1'b0;
      freq_q <= 2'b00;
      mode_q <= OSC_NOISE_IMM;
      trim_q <= `RTCU_TRIM_RST;
    end
    else
    begin
      flag_q <= flag_d;
      if (we_ctrl)
      begin
        wen_q <= hwdata[`RTCU_CTRL_WEN];
        ss_en_q <= hwdata[`RTCU_CTRL_SSEN];
        sq_en_q <= hwdata[`RTCU_CTRL_SQEN];
        freq_q <= hwdata[`RTCU_FREQ_HI:`RTCU_FREQ_LO];
        mode_q <= rtcu_osc_mode_t'(hwdata[`RTCU_MODE_HI:`RTCU_MODE_LO]);
      end
      // Gate is the stored bit, so a single write cannot open and use it
      if (we_ctrl && wen_q)
        enable_q <= hwdata[`RTCU_CTRL_EN];
      if (we_trim && wen_q)
        trim_q <= hwdata[`RTCU_TRIM_HI:0];
    end
  end

  // Reserved bits are never stored and read back as zero
  wire [31:0] ctrl_rd = {16'h0000, wen_q, 2'b00, mode_q, freq_q, sq_en_q, flag_q,
                         3'b000, busy_w, ss_en_q, 1'b0, enable_q};

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisation busy

  wire sync_start = we_ctrl || we_trim || we_sec || we_ssec || we_rssa;
  logic sync_done;

  rtcu_oneshot #(.CYCLES(SYNC_CYCLES)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .start(sync_start),
    .busy(busy_w),
    .done(sync_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counters and sub-second alarm

  rtcu_wave_if w_if ();
  assign w_if.run = enable_q;
  assign w_if.trim = trim_q;

  rtcu_wave_gen #(.TICK_CYCLES(TICK_CYCLES)) u_wave (
    .clk(hclk),
    .rst_n(hresetn),
    .w(w_if)
  );

  logic [31:0] sec_q;
  logic [7:0] ssec_q;
  logic [31:0] rssa_q;
  logic [31:0] acnt_q;

  wire ss_tick = w_if.tick256 && enable_q;
  wire ss_wrap = ss_tick && (&ssec_q);
  assign alarm_evt = ss_tick && ss_en_q && (&acnt_q);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sec_q <= `RTCU_SEC_RST;
      ssec_q <= `RTCU_SSEC_RST;
      rssa_q <= 32'h0000_0000;
      acnt_q <= 32'h0000_0000;
    end
    else
    begin
      if (we_sec)
        sec_q <= hwdata;
      else if (ss_wrap)
        sec_q <= sec_q + 32'h0000_0001;
      if (we_ssec)
        ssec_q <= hwdata[7:0];
      else if (ss_tick)
        ssec_q <= ssec_q + 8'h01;
      if (we_rssa)
        rssa_q <= hwdata;
      // Alarm counts up from the start value, fires on the tick past all ones and reloads the start value
      if (we_rssa)
        acnt_q <= hwdata;
      else if (!ss_en_q || alarm_evt)
        acnt_q <= rssa_q;
      else if (ss_tick)
        acnt_q <= acnt_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator mode and processor hold

  rtcu_osc_state_t st_q;
  rtcu_osc_state_t st_d;
  logic warm_done;
  logic hold_q;
  logic quiet_q;
  wire auto_mode = (mode_q == OSC_AUTO_WAIT) || (mode_q == OSC_AUTO_NOWAIT);
  wire warm_start = (st_q == ST_DEEP) && !deep_low_power_state && (mode_q == OSC_AUTO_WAIT);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_RUN:
        st_d = deep_low_power_state ? ST_DEEP : ST_RUN;
      ST_DEEP:
        if (!deep_low_power_state)
          st_d = warm_start ? ST_WARM : ST_RUN;
      ST_WARM:
        st_d = warm_done ? ST_RUN : ST_WARM;
      default:
        st_d = ST_RUN;
    endcase
  end

  rtcu_oneshot #(.CYCLES(WARM_CYCLES)) u_warm (
    .clk(hclk),
    .rst_n(hresetn),
    .start(warm_start),
    .busy(),
    .done(warm_done)
  );

  // Quiet only when asked for outright or while in deep sleep under an auto mode
  wire quiet_d = (mode_q == OSC_QUIET) || (auto_mode && deep_low_power_state);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= ST_RUN;
      hold_q <= 1'b0;
      quiet_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      hold_q <= (st_d == ST_WARM);
      quiet_q <= quiet_d;
    end
  end

  assign cpu_hold = hold_q;
  assign osc_quiet_mode = quiet_q;

  ////////////////////////////////////////////////////////////////////////////
  // Calibration output

  logic cal_q;
  wire wave_sel = freq_q[1] ? w_if.sq_4khz : (freq_q[0] ? w_if.sq_512hz : w_if.sq_1hz);
  wire cal_d = sq_en_q && cal_alt_func_sel && wave_sel;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cal_q <= 1'b0;
    else
      cal_q <= cal_d;
  end

  assign calibration_output_pin = cal_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and wake-up

  logic [`RTCU_IRQ_W-1:0] stat_q;
  logic [`RTCU_IRQ_W-1:0] mask_q;
  logic irq_q;
  logic wake_q;
  wire [`RTCU_IRQ_W-1:0] evt = {sync_done, ss_wrap, alarm_evt};
  wire [`RTCU_IRQ_W-1:0] w1c = we_stat ? hwdata[`RTCU_IRQ_W-1:0] : '0;
  wire [`RTCU_IRQ_W-1:0] stat_d = evt | (stat_q & ~w1c);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stat_q <= `RTCU_STAT_RST;
      mask_q <= `RTCU_STAT_RST;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= we_mask ? hwdata[`RTCU_IRQ_W-1:0] : mask_q;
      irq_q <= |(stat_d & (we_mask ? hwdata[`RTCU_IRQ_W-1:0] : mask_q));
      wake_q <= flag_d;
    end
  end

  assign irq = irq_q;
  assign wake_request = wake_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection; unmapped offsets read zero

  assign rd_mux = (addr_q == `RTCU_OFF_SEC) ? sec_q :
                  (addr_q == `RTCU_OFF_SSEC) ? {24'h000000, ssec_q} :
                  (addr_q == `RTCU_OFF_RSSA) ? rssa_q :
                  (addr_q == `RTCU_OFF_CTRL) ? ctrl_rd :
                  (addr_q == `RTCU_OFF_TRIM) ? {24'h000000, trim_q} :
                  (addr_q == `RTCU_OFF_STAT) ? {29'h0000_0000, stat_q} :
                  (addr_q == `RTCU_OFF_MASK) ? {29'h0000_0000, mask_q} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_wake_wait;
    (st_q == ST_DEEP) && !deep_low_power_state && (mode_q == OSC_AUTO_WAIT);
  endsequence

  sequence s_wake_nowait;
    (st_q == ST_DEEP) && !deep_low_power_state && (mode_q == OSC_AUTO_NOWAIT);
  endsequence

  sequence s_sec_wrap;
    ss_wrap && !we_sec && !we_ssec;
  endsequence

  a_gate_enable: assert property ((we_ctrl && !wen_q) |=> enable_q == $past(enable_q))
    else $error("clock enable changed with write gate closed");
  a_gate_trim: assert property ((we_trim && !wen_q) |=> trim_q == $past(trim_q))
    else $error("trim changed with write gate closed");
  a_reserved_zero: assert property ((rd_q && addr_q == `RTCU_OFF_CTRL) |=>
    (rdata_q[31:16] == 16'h0000) && (rdata_q[14:13] == 2'b00))
    else $error("reserved control bits read nonzero");
  a_mode_quiet: assert property ((mode_q == OSC_QUIET) |=> quiet_q)
    else $error("mode 1 not quiet");
  a_mode_noise: assert property ((mode_q == OSC_NOISE_IMM) |=> !quiet_q)
    else $error("mode 0 not noise immune");
  a_warm_hold: assert property (s_wake_wait |=> cpu_hold [*2])
    else $error("no processor hold during warm-up");
  a_nowait_free: assert property (s_wake_nowait |=> !cpu_hold)
    else $error("processor held in mode 3");
  a_raw_select: assert property ((sq_en_q && cal_alt_func_sel && freq_q[1]) |=>
    calibration_output_pin == $past(w_if.sq_4khz))
    else $error("raw wave not selected");
  a_cal_off: assert property (!(sq_en_q && cal_alt_func_sel) |=> !calibration_output_pin)
    else $error("calibration pin driven while disabled");
  a_flag_set: assert property (alarm_evt |=> flag_q && wake_request)
    else $error("alarm flag or wake-up missing");
  a_flag_sticky: assert property ((flag_q && !flag_clr) |=> flag_q)
    else $error("alarm flag lost without a clearing write");
  a_busy_rise: assert property (sync_start |=> busy_w [*2])
    else $error("busy not shown after register change");
  a_sec_carry: assert property (s_sec_wrap |=> (sec_q == $past(sec_q) + 32'h0000_0001) && (ssec_q == 8'h00))
    else $error("seconds not advanced on sub-second wrap");
endmodule

// >>> verif/rtc_control_upper_bits_test.sv
// Self-checking bench for the timekeeper control block, driven over AHB-Lite.
// Assumes rtcu_top as the only slave; counts shortened by parameters.
`timescale 1ns/1ps
`include "rtcu_regs.svh"
module rtc_control_upper_bits_test;
  import rtcu_pkg::*;
  localparam int TICK = 8;
  localparam logic [31:0] GATE = 32'h0000_8000;
  localparam logic [31:0] EN = 32'h0000_0001;
  localparam logic [31:0] SQ = 32'h0000_0100;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic deep_low_power_state = 1'b0;
  logic cal_alt_func_sel = 1'b0;
  wire hready;
  wire [31:0] hrdata;
  wire calibration_output_pin;
  wire osc_quiet_mode;
  wire cpu_hold;
  wire wake_request;
  wire irq;
  wire hresp;
  int n_errors = 0;
  int checks_done = 0;
  logic [31:0] r;

  always #5 hclk = ~hclk;

  rtcu_top #(.TICK_CYCLES(TICK), .SYNC_CYCLES(4), .WARM_CYCLES(4)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .deep_low_power_state(deep_low_power_state), .cal_alt_func_sel(cal_alt_func_sel),
    .calibration_output_pin(calibration_output_pin), .osc_quiet_mode(osc_quiet_mode),
    .cpu_hold(cpu_hold), .wake_request(wake_request), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // Ready is read before the edge's updates land, as the master sees it
  task automatic wait_rdy();
    for (int i = 0; i < 50; i++)
    begin
      @(posedge hclk);
      if (hready === 1'b1)
        return;
    end
    n_errors++;
    summarize();
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h0, q);
  endtask

  // Busy does not block writes, so every change waits for it to clear
  task automatic idle();
    logic [31:0] q;
    for (int i = 0; i < 50; i++)
    begin
      rd(`RTCU_OFF_CTRL, q);
      if (q[3] === 1'b0)
        return;
    end
    n_errors++;
    summarize();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
    idle();
  endtask

  task automatic count_edges(output int n);
    logic prev;
    n = 0;
    prev = calibration_output_pin;
    repeat (512)
    begin
      @(posedge hclk);
      if (calibration_output_pin !== prev)
        n++;
      prev = calibration_output_pin;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`RTCU_OFF_CTRL, r);
    check(r, 32'h0);
    check({cpu_hold, osc_quiet_mode, calibration_output_pin, irq, wake_request}, 5'h0);
    check(hresp, 1'b0);
    rd(8'h18, r);
    check(r, 32'h0);
  endtask

  task automatic t_gate();
    wr(`RTCU_OFF_CTRL, EN);
    rd(`RTCU_OFF_CTRL, r);
    check(r & ~32'h8, 32'h0);
    wr(`RTCU_OFF_TRIM, 32'h5);
    rd(`RTCU_OFF_TRIM, r);
    check(r, 32'h0);
    wr(`RTCU_OFF_CTRL, GATE);
    wr(`RTCU_OFF_CTRL, GATE | EN);
    rd(`RTCU_OFF_CTRL, r);
    check(r & ~32'h8, GATE | EN);
    wr(`RTCU_OFF_TRIM, 32'h3);
    rd(`RTCU_OFF_TRIM, r);
    check(r, 32'h3);
    wr(`RTCU_OFF_TRIM, 32'h0);
  endtask

  // Counter loaded near wrap so the seconds step shows within two ticks
  task automatic t_count();
    wr(`RTCU_OFF_CTRL, GATE);
    wr(`RTCU_OFF_SEC, 32'h5);
    wr(`RTCU_OFF_SSEC, 32'hfe);
    bus(`RTCU_OFF_CTRL, 1'b1, GATE | EN, r);
    rd(`RTCU_OFF_CTRL, r);
    check(r[3], 1'b1);
    idle();
    cyc(600);
    rd(`RTCU_OFF_SEC, r);
    check(r, 32'h6);
    rd(`RTCU_OFF_SSEC, r);
    check(r <= 32'h1, 1'b1);
  endtask

  task automatic t_osc();
    for (int m = 0; m < 4; m++)
    begin
      wr(`RTCU_OFF_CTRL, GATE | EN | (m << 11));
      cyc(2);
      check(osc_quiet_mode, m == 1);
      deep_low_power_state <= 1'b1;
      cyc(3);
      check(osc_quiet_mode, m != 0);
      deep_low_power_state <= 1'b0;
      cyc(3);
      check(cpu_hold, m == 2);
      check(osc_quiet_mode, m == 1);
      cyc(10);
      check(cpu_hold, 1'b0);
    end
  endtask

  // Toggle counts over 512 clocks, one edge of slack for phase
  task automatic t_cal();
    int n;
    int e;
    for (int f = 0; f < 4; f++)
    begin
      e = f[1] ? 512 / TICK : (f[0] ? 512 / (8 * TICK) : 0);
      wr(`RTCU_OFF_CTRL, GATE | EN | SQ | (f << 9));
      cal_alt_func_sel <= 1'b0;
      // Pin lags its inputs by a clock; a high level left over would count as an edge
      cyc(2);
      count_edges(n);
      check(n, 0);
      cal_alt_func_sel <= 1'b1;
      cyc(2);
      count_edges(n);
      check(n >= e - 1 && n <= e + 1, 1'b1);
    end
    wr(`RTCU_OFF_CTRL, GATE | EN | (2 << 9));
    cyc(2);
    count_edges(n);
    check(n, 0);
    check(calibration_output_pin, 1'b0);
  endtask

  task automatic t_alarm();
    int i;
    wr(`RTCU_OFF_RSSA, 32'hffff_fffd);
    wr(`RTCU_OFF_MASK, 32'h1);
    wr(`RTCU_OFF_STAT, 32'h7);
    wr(`RTCU_OFF_CTRL, GATE | EN | 32'h4);
    for (i = 0; i < 2000 && wake_request !== 1'b1; i++)
      @(posedge hclk);
    check(wake_request, 1'b1);
    rd(`RTCU_OFF_CTRL, r);
    check(r[7], 1'b1);
    check(irq, 1'b1);
    wr(`RTCU_OFF_CTRL, GATE | EN | 32'h80);
    rd(`RTCU_OFF_CTRL, r);
    check(r[7], 1'b1);
    wr(`RTCU_OFF_MASK, 32'h0);
    cyc(2);
    check(irq, 1'b0);
    wr(`RTCU_OFF_MASK, 32'h1);
    cyc(2);
    check(irq, 1'b1);
    wr(`RTCU_OFF_STAT, 32'h1);
    rd(`RTCU_OFF_STAT, r);
    check(r[0], 1'b0);
    cyc(2);
    check(irq, 1'b0);
    wr(`RTCU_OFF_CTRL, GATE | EN);
    rd(`RTCU_OFF_CTRL, r);
    check(r[7], 1'b0);
    cyc(2);
    check(wake_request, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(5);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_gate();
    t_count();
    t_osc();
    t_cal();
    t_alarm();
    summarize();
  end
endmodule
